// ---- pds_pwm_steer.sv ----
// Purpose: pwm delay, auto-restart and output steering with axi4-lite registers
// Assumes: pwm_sched and pwm_period_start come from the pwm timebase on aclk
// Notes: pins A..D are index 0..3; released pins follow port_out/port_oe
// How it works
// RULE_01: active edge delayed by count instruction cycles
// RULE_02: sync set: steering changes at period start
// RULE_03: sync clear: steering changes at instruction tick
// RULE_04: enabled pin drives pwm with mode polarity
// RULE_05: disabled pin returns to general port control
// RULE_06: steering only in pwm mode, single config
// RULE_07: restart enable clears shutdown status automatically
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
module pds_pwm_steer
  import pds_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_sched,
  input wire logic pwm_period_start,
  input wire logic shutdown_event,
  input wire logic [3:0] capture_compare_mode_field,
  input wire logic [1:0] enhanced_output_config,
  input wire logic [PIN_N-1:0] port_out,
  input wire logic [PIN_N-1:0] port_oe,
  output logic [PIN_N-1:0] pwm_pin_out,
  output logic [PIN_N-1:0] pwm_pin_oe,
  output logic irq
);
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return a == ADDR_DLY_CTRL || a == ADDR_STEER_CTRL || a == ADDR_SHDN ||
      a == ADDR_IRQ_STAT || a == ADDR_IRQ_MASK || a == ADDR_STATE;
  endfunction

  // A and C take mode bit 1, B and D take mode bit 0
  function automatic logic pin_level(input logic pwm, input logic [3:0] mode, input int idx);
    return pwm ^ ((idx % 2 == 0) ? mode[1] : mode[0]);
  endfunction

  pds_dly_if dl ();

  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] dly_ctrl_q;
  logic [4:0] steer_ctrl_q;
  logic [PIN_N-1:0] steer_applied_q;
  logic shdn_status_q;
  logic [IRQ_N-1:0] irq_stat_q, irq_mask_q, irq_evt, irq_rd_clr;
  logic [DIV_W-1:0] div_q;
  logic tick_q;
  logic wr_go, aw_hs, w_hs, ar_hs, wr_en, steer_load, steer_mode, shdn_sw_clr;
  logic [PIN_N-1:0] pin_out_q, pin_oe_q;

  assign aw_hs = s_axi_awvalid && awready_q;
  assign w_hs = s_axi_wvalid && wready_q;
  assign ar_hs = s_axi_arvalid && arready_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en = wr_go && wstrb_q[0] && addr_known(awaddr_q);

  // write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_have_q <= (aw_have_q && !wr_go) || aw_hs;
      w_have_q <= (w_have_q && !wr_go) || w_hs;
      awready_q <= !((aw_have_q && !wr_go) || aw_hs);
      wready_q <= !((w_have_q && !wr_go) || w_hs);
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= ar_hs || (rvalid_q && !s_axi_rready);
      arready_q <= !(ar_hs || (rvalid_q && !s_axi_rready));
      if (ar_hs) begin
        rresp_q <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          ADDR_DLY_CTRL: rdata_q <= {24'h00_0000, dly_ctrl_q};
          ADDR_STEER_CTRL: rdata_q <= {27'h000_0000, steer_ctrl_q};
          ADDR_SHDN: rdata_q <= {31'h0000_0000, shdn_status_q};
          ADDR_IRQ_STAT: rdata_q <= {30'h0000_0000, irq_stat_q};
          ADDR_IRQ_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
          ADDR_STATE: rdata_q <= {27'h000_0000, dl.pwm_delayed, steer_applied_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_ctrl_q <= DLY_CTRL_RST;
      steer_ctrl_q <= STEER_CTRL_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_en) begin
      if (awaddr_q == ADDR_DLY_CTRL) begin
        dly_ctrl_q <= wdata_q[7:0];
      end
      if (awaddr_q == ADDR_STEER_CTRL) begin
        steer_ctrl_q <= wdata_q[4:0];
      end
      if (awaddr_q == ADDR_IRQ_MASK) begin
        irq_mask_q <= wdata_q[IRQ_N-1:0];
      end
    end
  end

  // instruction cycle divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_q + DIV_W'(1);
      tick_q <= div_q == DIV_W'(INSTR_CLKS - 1);
    end
  end

  // RULE_02: period start when synced
  // RULE_03: next tick otherwise
  assign steer_load = steer_ctrl_q[SYNC_BIT] ? pwm_period_start : tick_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      steer_applied_q <= STEER_CTRL_RST[PIN_N-1:0];
    end else if (steer_load) begin
      steer_applied_q <= steer_ctrl_q[PIN_N-1:0];
    end
  end

  // RULE_07: restart or software clear
  assign shdn_sw_clr = wr_en && awaddr_q == ADDR_SHDN && !wdata_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shdn_status_q <= 1'b0;
    end else if (shutdown_event) begin
      shdn_status_q <= 1'b1;
    end else if (dly_ctrl_q[RESTART_BIT] || shdn_sw_clr) begin
      shdn_status_q <= 1'b0;
    end
  end

  // sticky events, cleared by reading, set wins
  assign irq_evt[IRQ_SHDN] = shutdown_event && !shdn_status_q;
  assign irq_evt[IRQ_STEER] = steer_load && steer_applied_q != steer_ctrl_q[PIN_N-1:0];
  assign irq_rd_clr = (ar_hs && s_axi_araddr == ADDR_IRQ_STAT) ? irq_stat_q : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_rd_clr) | irq_evt;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // RULE_01: shutdown forces inactive
  assign dl.pwm_sched = pwm_sched && !shdn_status_q;
  assign dl.tick = tick_q;
  assign dl.active_edge_delay_count = dly_ctrl_q[DLY_W-1:0];

  pds_delay_unit u_dly (
    .aclk(aclk),
    .aresetn(aresetn),
    .dl(dl)
  );

  // RULE_06: pwm mode and single config
  assign steer_mode = capture_compare_mode_field[3:2] == MODE_PWM &&
    enhanced_output_config == CFG_SINGLE;

  for (genvar gi = 0; gi < PIN_N; gi++) begin : g_pin
    // RULE_04: steered pin with polarity
    // RULE_05: released pin to port
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_out_q[gi] <= 1'b0;
        pin_oe_q[gi] <= 1'b0;
      end else if (steer_mode && steer_applied_q[gi]) begin
        pin_out_q[gi] <= pin_level(dl.pwm_delayed, capture_compare_mode_field, gi);
        pin_oe_q[gi] <= 1'b1;
      end else begin
        pin_out_q[gi] <= port_out[gi];
        pin_oe_q[gi] <= port_oe[gi];
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pwm_pin_out = pin_out_q;
  assign pwm_pin_oe = pin_oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sync_hold;
    steer_ctrl_q[SYNC_BIT] && !pwm_period_start |=> $stable(steer_applied_q);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("steering moved off period"); // RULE_02

  property p_sync_apply;
    steer_ctrl_q[SYNC_BIT] && pwm_period_start |=>
      steer_applied_q == $past(steer_ctrl_q[PIN_N-1:0]);
  endproperty
  a_sync_apply: assert property (p_sync_apply) else $error("period start missed"); // RULE_02

  property p_tick_apply;
    !steer_ctrl_q[SYNC_BIT] ##0 $stable(steer_ctrl_q) [*5] |->
      steer_applied_q == steer_ctrl_q[PIN_N-1:0];
  endproperty
  a_tick_apply: assert property (p_tick_apply) else $error("tick update late"); // RULE_03

  property p_drive_a;
    steer_mode && steer_applied_q[0] |=> pwm_pin_oe[0] &&
      pwm_pin_out[0] == ($past(dl.pwm_delayed) ^ $past(capture_compare_mode_field[1]));
  endproperty
  a_drive_a: assert property (p_drive_a) else $error("pin A not steered"); // RULE_04

  property p_drive_b;
    steer_mode && steer_applied_q[1] |=> pwm_pin_oe[1] &&
      pwm_pin_out[1] == ($past(dl.pwm_delayed) ^ $past(capture_compare_mode_field[0]));
  endproperty
  a_drive_b: assert property (p_drive_b) else $error("pin B not steered"); // RULE_04

  property p_release;
    !steer_applied_q[3] |=> pwm_pin_oe[3] == $past(port_oe[3]) &&
      pwm_pin_out[3] == $past(port_out[3]);
  endproperty
  a_release: assert property (p_release) else $error("pin D not released"); // RULE_05

  property p_ignore;
    !steer_mode |=> pwm_pin_oe == $past(port_oe) && pwm_pin_out == $past(port_out);
  endproperty
  a_ignore: assert property (p_ignore) else $error("steering outside pwm mode"); // RULE_06

  property p_restart;
    shdn_status_q && dly_ctrl_q[RESTART_BIT] && !shutdown_event |=> !shdn_status_q;
  endproperty
  a_restart: assert property (p_restart) else $error("auto restart failed"); // RULE_07

  property p_latched;
    shdn_status_q && !dly_ctrl_q[RESTART_BIT] && !shdn_sw_clr |=> shdn_status_q;
  endproperty
  a_latched: assert property (p_latched) else $error("shutdown status dropped"); // RULE_07

  c_sync_change: cover property (steer_ctrl_q[SYNC_BIT] && irq_evt[IRQ_STEER]);
  c_restart: cover property (shdn_status_q && dly_ctrl_q[RESTART_BIT] ##1 !shdn_status_q);
  c_irq: cover property ($rose(irq));
endmodule

// ---- pds_pkg.sv ----
// Purpose: shared constants for the pwm delay and output steering block
// Assumes: 32-bit axi4-lite register bus, registers of 1 to 8 bits in the low byte
// Notes: aclk is the oscillator; one instruction cycle is four aclk cycles
package pds_pkg;
  localparam int DLY_W = 7;
  localparam int PIN_N = 4;
  localparam int ADDR_W = 8;
  localparam int INSTR_CLKS = 4;
  localparam int DIV_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_DLY_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STEER_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SHDN = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h14;
  localparam int RESTART_BIT = 7;
  localparam int SYNC_BIT = 4;
  localparam int IRQ_N = 2;
  localparam int IRQ_SHDN = 0;
  localparam int IRQ_STEER = 1;
  localparam logic [7:0] DLY_CTRL_RST = 8'h00;
  localparam logic [4:0] STEER_CTRL_RST = 5'h01;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- pds_dly_if.sv ----
// Purpose: carries the scheduled pwm into the active edge delay unit
// Assumes: single aclk domain
// Notes: ctl side is the register/steering logic, dly side the delay unit
interface pds_dly_if;
  logic pwm_sched;
  logic tick;
  logic [6:0] active_edge_delay_count;
  logic pwm_delayed;
  modport ctl (output pwm_sched, output tick, output active_edge_delay_count, input pwm_delayed);
  modport dly (input pwm_sched, input tick, input active_edge_delay_count, output pwm_delayed);
endinterface

// ---- pds_delay_unit.sv ----
// Purpose: delays the rising (active) edge of the pwm by whole instruction cycles
// Assumes: tick is a one-cycle pulse every instruction cycle
// Notes: the falling edge passes with one cycle of latency
module pds_delay_unit
  import pds_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  pds_dly_if.dly dl
);
  logic sched_q;
  logic pend_q;
  logic out_q;
  logic [DLY_W-1:0] count_q;
  logic rise;
  logic fall;

  assign rise = dl.pwm_sched && !sched_q;
  assign fall = !dl.pwm_sched && sched_q;
  assign dl.pwm_delayed = out_q;

  // RULE_01: count ticks before active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sched_q <= 1'b0;
      pend_q <= 1'b0;
      out_q <= 1'b0;
      count_q <= '0;
    end else begin
      sched_q <= dl.pwm_sched;
      if (fall) begin
        out_q <= 1'b0;
        pend_q <= 1'b0;
      end else if (rise) begin
        if (dl.active_edge_delay_count == '0) begin
          out_q <= 1'b1;
        end else begin
          count_q <= dl.active_edge_delay_count;
          pend_q <= 1'b1;
        end
      end else if (pend_q && dl.tick) begin
        if (count_q == DLY_W'(1)) begin
          out_q <= 1'b1;
          pend_q <= 1'b0;
        end else begin
          count_q <= count_q - DLY_W'(1);
        end
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_dly_fall;
    fall |=> !out_q;
  endproperty
  a_dly_fall: assert property (p_dly_fall) else $error("output not low after fall"); // RULE_01

  property p_dly_zero;
    rise && dl.active_edge_delay_count == '0 |=> out_q;
  endproperty
  a_dly_zero: assert property (p_dly_zero) else $error("zero delay not immediate"); // RULE_01

  property p_dly_wait;
    rise && dl.active_edge_delay_count != '0 |=> !out_q ##1 (!out_q || $past(dl.tick));
  endproperty
  a_dly_wait: assert property (p_dly_wait) else $error("active edge came early"); // RULE_01

  property p_dly_cause;
    $rose(out_q) |-> $past(rise) || $past(pend_q && dl.tick && count_q == DLY_W'(1));
  endproperty
  a_dly_cause: assert property (p_dly_cause) else $error("active edge without cause"); // RULE_01

  c_dly_long: cover property (rise && dl.active_edge_delay_count > 7'h02 ##[8:40] $rose(out_q));
endmodule

// ---- pds_pin_load.sv ----
// Purpose: load on pins A..D, resolves the level seen at each pin
// Assumes: driver outputs and enables come from the block under test
// Notes: weak pull-down on every pin, so a pin with its enable low reads low
module pds_pin_load
  import pds_pkg::*;
(
  input wire logic [PIN_N-1:0] drv_out,
  input wire logic [PIN_N-1:0] drv_oe,
  output logic [PIN_N-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // undriven pin falls to the pull-down
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      pin_level[i] = drv_oe[i] ? drv_out[i] : 1'b0;
    end
  end
endmodule

// ---- tb_top.sv ----
// Purpose: register and pin tests of the pwm delay and steering block
// Assumes: 250 MHz aclk, no pwm period pulse unless a test gives one
// Notes: pins are sampled 1 ns after the clock edge
module tb_top
  import pds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [3:0] wstrb_sel = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sched = 1'b0;
  logic pstart = 1'b0;
  logic shdn = 1'b0;
  logic [3:0] mode = 4'hc;
  logic [1:0] cfg = '0;
  logic [3:0] pout = '0;
  logic [3:0] poe = '0;
  logic [3:0] pin_o, pin_oe, pin_lv;
  logic [31:0] d;
  logic [1:0] r;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #2 aclk = ~aclk;

  pds_pwm_steer i_pds_pwm_steer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_sched(sched), .pwm_period_start(pstart), .shutdown_event(shdn),
    .capture_compare_mode_field(mode), .enhanced_output_config(cfg),
    .port_out(pout), .port_oe(poe), .pwm_pin_out(pin_o), .pwm_pin_oe(pin_oe), .irq(irq));

  pds_pin_load i_pds_pin_load (.drv_out(pin_o), .drv_oe(pin_oe), .pin_level(pin_lv));

  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: reg %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: pins %b, want %b", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= wstrb_sel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // edge counts from sched rise and fall to pin A
  task automatic meas(input int n);
    int k;
    int lo;
    int hi;
    wr(ADDR_DLY_CTRL, 32'(n));
    lo = (n == 0) ? 2 : 4 * n - 2;
    hi = (n == 0) ? 2 : 4 * n + 3;
    settle(12);
    @(posedge aclk);
    sched <= 1'b1;
    k = 0;
    do begin
      settle(1);
      k++;
    end while (pin_lv[0] !== 1'b1 && k < 100);
    chk_reg(32'(k >= lo && k <= hi), 32'h0000_0001);
    @(posedge aclk);
    sched <= 1'b0;
    k = 0;
    do begin
      settle(1);
      k++;
    end while (pin_lv[0] !== 1'b0 && k < 100);
    chk_reg(32'(k), 32'h0000_0002);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    rd(ADDR_DLY_CTRL);
    chk_reg(d, 32'h0000_0000);
    chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_STATE);
    chk_reg(d, 32'h0000_0001);
    wr(8'h18, 32'h0000_007f);
    chk_reg({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h18);
    chk_reg(d, 32'h0000_0000);
    chk_reg({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(ADDR_DLY_CTRL, 32'hffff_ff85);
    rd(ADDR_DLY_CTRL);
    chk_reg(d, 32'h0000_0085);
    wstrb_sel = 4'he;
    wr(ADDR_DLY_CTRL, 32'h0000_0011);
    wstrb_sel = 4'hf;
    chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_DLY_CTRL);
    chk_reg(d, 32'h0000_0085);
    meas(0);
    meas(3);
    meas(9);
    wr(ADDR_DLY_CTRL, 32'h0000_0000);
    @(posedge aclk);
    sched <= 1'b1;
    wr(ADDR_STEER_CTRL, 32'h0000_000f);
    settle(5);
    rd(ADDR_STATE);
    chk_reg(d, 32'h0000_001f);
    for (int m = 0; m < 4; m++) begin
      @(posedge aclk);
      mode <= {2'b11, 2'(m)};
      settle(4);
      chk_pin(pin_oe, 4'hf);
      chk_pin(pin_lv, 4'hf ^ {mode[0], mode[1], mode[0], mode[1]});
    end
    @(posedge aclk);
    mode <= 4'hc;
    wr(ADDR_STEER_CTRL, 32'h0000_0013);
    settle(12);
    rd(ADDR_STATE);
    chk_reg(d, 32'h0000_001f);
    @(posedge aclk);
    pstart <= 1'b1;
    @(posedge aclk);
    pstart <= 1'b0;
    settle(2);
    rd(ADDR_STATE);
    chk_reg(d, 32'h0000_0013);
    @(posedge aclk);
    pout <= 4'b1010;
    poe <= 4'b0110;
    wr(ADDR_STEER_CTRL, 32'h0000_0005);
    settle(6);
    chk_pin(pin_oe, 4'b0111);
    chk_pin(pin_lv, 4'b0111);
    for (int c = 0; c < 2; c++) begin
      @(posedge aclk);
      cfg <= (c == 0) ? 2'b01 : 2'b00;
      mode <= (c == 0) ? 4'hc : 4'h8;
      settle(3);
      chk_pin(pin_oe, 4'b0110);
      chk_pin(pin_lv, 4'b0010);
    end
    @(posedge aclk);
    mode <= 4'hc;
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    rd(ADDR_IRQ_STAT);
    chk_reg(d, 32'h0000_0002);
    @(posedge aclk);
    shdn <= 1'b1;
    settle(4);
    chk_reg({31'h0, irq}, 32'h0000_0001);
    chk_pin(pin_lv, 4'b0010);
    @(posedge aclk);
    shdn <= 1'b0;
    settle(4);
    rd(ADDR_SHDN);
    chk_reg(d, 32'h0000_0001);
    rd(ADDR_IRQ_STAT);
    chk_reg(d & 32'h0000_0001, 32'h0000_0001);
    rd(ADDR_IRQ_STAT);
    chk_reg(d, 32'h0000_0000);
    settle(2);
    chk_reg({31'h0, irq}, 32'h0000_0000);
    wr(ADDR_SHDN, 32'h0000_0000);
    rd(ADDR_SHDN);
    chk_reg(d, 32'h0000_0000);
    settle(3);
    chk_pin(pin_lv, 4'b0111);
    wr(ADDR_DLY_CTRL, 32'h0000_0080);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    @(posedge aclk);
    shdn <= 1'b1;
    settle(4);
    chk_reg({31'h0, irq}, 32'h0000_0000);
    rd(ADDR_SHDN);
    chk_reg(d, 32'h0000_0001);
    @(posedge aclk);
    shdn <= 1'b0;
    settle(4);
    rd(ADDR_SHDN);
    chk_reg(d, 32'h0000_0000);
    chk_pin(pin_lv, 4'b0111);
    print_verdict();
  end
endmodule
